// >>> pkg/acr_if.sv
// Internal memory bus between the controller and the converter registers.
// Assumes both ends share one clock; the testbench joins the two ends here.
`timescale 1ns/10ps
`default_nettype none
interface acr_if;
    logic req;
    logic we;
    logic word;
    logic bitop;
    logic [2:0] bit_idx;
    logic bit_val;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic ready;
    logic irq;
    modport dev (
        input req, we, word, bitop, bit_idx, bit_val, addr, wdata,
        output rdata, ready, irq
    );
    modport host (
        output req, we, word, bitop, bit_idx, bit_val, addr, wdata,
        input rdata, ready, irq
    );
endinterface : acr_if
`default_nettype wire

// >>> pkg/acr_pkg.sv
// Shared constants for the converter register block and its controller.
// Assumes one 10 MHz clock and an active-low asynchronous reset at both ends.
package acr_pkg;
    // Device register byte addresses on the internal memory bus
    localparam logic [15:0] ADDR_RESULT_LO = 16'hff08;
    localparam logic [15:0] ADDR_RESULT_HI = 16'hff09;
    localparam logic [15:0] ADDR_CHAN = 16'hff29;
    localparam logic [15:0] ADDR_MODE = 16'hff2a;
    localparam logic [15:0] ADDR_THR = 16'hff2b;
    localparam logic [15:0] ADDR_CONV_MODE = 16'hff28;
    // Reset values
    localparam logic [2:0] CHAN_RST = 3'h0;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [7:0] THR_RST = 8'h00;
    // Field positions
    localparam int MODE_EN_BIT = 7;
    localparam int MODE_POL_BIT = 6;
    localparam int CHAN_BITS = 3;
    localparam int RESULT_SHIFT = 6;
    // Bus wait cycles inserted by the device
    localparam logic [1:0] WAIT_CYCLES = 2'h1;
    // Controller registers, AXI4-Lite byte offsets
    localparam logic [7:0] OFS_ADDR = 8'h00;
    localparam logic [7:0] OFS_WDATA = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_RDATA = 8'h10;
    // Command register fields
    localparam int CMD_WRITE = 0;
    localparam int CMD_WORD = 1;
    localparam int CMD_BITOP = 2;
    localparam int CMD_IDX_LO = 4;
    localparam int CMD_BITVAL = 7;
    // Status register fields
    localparam int ST_BUSY = 0;
    localparam int ST_REFUSED = 1;
    localparam int ST_UNREAD = 2;
    localparam int ST_IRQ_LO = 8;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Device bus sequencer
    typedef enum logic [1:0] {DEV_IDLE, DEV_WAIT, DEV_ANS} acr_dev_st_t;
    // Controller access sequencer
    typedef enum logic {HOST_IDLE, HOST_REQ} acr_host_st_t;
endpackage : acr_pkg

// >>> rtl/acr_device.sv
// Channel select, result, compare mode and threshold registers of a
// 10-bit converter, with the conditional conversion-done interrupt.
// Assumes a sequencer outside that pulses conv_done with a fresh result
// and restarts on conv_abort; the controller holds req until ready.
//
// Notes on behaviour
// - Channel select resets zero, picks input 0-7
// - Software writes zeros to select bits 3-7
// - Select and mode accept bit and byte writes
// - Writes to select/mode/threshold add a wait
// - Result is 16 bits, low six zero
// - Each completion loads result from approximation register
// - High byte gives top eight, low byte two
// - Result read-only, read as one word; byte reads of either result address are also answered
// - Reset leaves result register uninitialised
// - Select writes may corrupt; read result first
// - Result reads add a bus wait cycle
// - Mode resets zero, bit 7 enables compare
// - Polarity bit picks at-least or below threshold
// - Threshold compared with high result byte
// - Threshold byte resets zero, byte writes only
// - Compare off: interrupt after every conversion
// - Compare once per conversion, on fresh result
// - Register writes abort and restart conversion
`timescale 1ns/10ps
`default_nettype none
module acr_device #(
    parameter int RES_W = 10,
    parameter int CH_W = 3
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Memory bus from the controller
    acr_if.dev bus,
    // Conversion sequencer
    input wire logic conv_done,
    input wire logic [RES_W-1:0] sar_value,
    output logic conv_abort,
    // Analog multiplexer select
    output logic [CH_W-1:0] channel_sel
);
    // The register layout only serves the documented widths
    if (RES_W != 10 || CH_W != acr_pkg::CHAN_BITS) begin : g_chk
        $error("acr_device serves only a 10-bit result and 3 select bits");
    end

    // True for accesses that cost an extra bus wait cycle
    function automatic logic needs_wait(input logic [15:0] a,
                                        input logic w);
        logic r;
        r = 1'b0;
        if (w && (a == acr_pkg::ADDR_CHAN || a == acr_pkg::ADDR_MODE ||
                  a == acr_pkg::ADDR_THR)) begin
            r = 1'b1;
        end else if (!w && (a == acr_pkg::ADDR_RESULT_LO ||
                            a == acr_pkg::ADDR_RESULT_HI)) begin
            r = 1'b1;
        end
        return r;
    endfunction : needs_wait

    // New byte value for a bit or byte write
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic bop,
                                         input logic [2:0] idx,
                                         input logic val,
                                         input logic [7:0] data);
        logic [7:0] r;
        r = data;
        if (bop) begin
            r = old;
            r[idx] = val;
        end
        return r;
    endfunction : merge

    acr_pkg::acr_dev_st_t state_q, state_d;
    logic [1:0] wcnt_q, wcnt_d;
    logic ready_q, ready_d;
    logic [15:0] rdata_q, rdata_d;
    logic [2:0] chan_q, chan_d;
    logic [1:0] mode_q, mode_d;
    logic [7:0] thr_q, thr_d;
    logic abort_q, abort_d;
    logic [RES_W-1:0] result_q;
    logic eval_q, eval_d;
    logic irq_q, irq_d;
    logic [15:0] result_word;
    logic [7:0] result_hi;
    logic [7:0] mode_byte;
    logic [7:0] nb;
    logic hit;

    // Left-justified view of the result; the low six bits are wired zero
    assign result_word = {result_q, {acr_pkg::RESULT_SHIFT{1'b0}}};
    assign result_hi = result_q[RES_W-1 -: 8];
    assign mode_byte = {mode_q, 6'h00};

    // Bus sequencer and register writes; the action happens on entry to
    // DEV_ANS, so a held req is never taken twice
    always_comb begin
        state_d = state_q;
        wcnt_d = wcnt_q;
        ready_d = 1'b0;
        rdata_d = rdata_q;
        chan_d = chan_q;
        mode_d = mode_q;
        thr_d = thr_q;
        abort_d = 1'b0;
        hit = 1'b0;
        nb = 8'h00;
        case (state_q)
            acr_pkg::DEV_IDLE: begin
                if (bus.req) begin
                    if (needs_wait(bus.addr, bus.we)) begin
                        state_d = acr_pkg::DEV_WAIT;
                        wcnt_d = acr_pkg::WAIT_CYCLES;
                    end else begin
                        hit = 1'b1;
                    end
                end
            end
            acr_pkg::DEV_WAIT: begin
                wcnt_d = wcnt_q - 2'h1;
                if (wcnt_q == 2'h1) begin
                    hit = 1'b1;
                end
            end
            acr_pkg::DEV_ANS: begin
                state_d = acr_pkg::DEV_IDLE;
            end
            default: begin
                state_d = acr_pkg::DEV_IDLE;
            end
        endcase
        if (hit) begin
            state_d = acr_pkg::DEV_ANS;
            ready_d = 1'b1;
            rdata_d = 16'h0000;
            if (bus.we) begin
                if (bus.addr == acr_pkg::ADDR_CHAN) begin
                    nb = merge({5'h00, chan_q}, bus.bitop, bus.bit_idx,
                               bus.bit_val, bus.wdata[7:0]);
                    chan_d = nb[2:0]; // upper bits dropped
                    abort_d = 1'b1;
                end else if (bus.addr == acr_pkg::ADDR_MODE) begin
                    nb = merge(mode_byte, bus.bitop, bus.bit_idx,
                               bus.bit_val, bus.wdata[7:0]);
                    mode_d = nb[acr_pkg::MODE_EN_BIT:acr_pkg::MODE_POL_BIT];
                    abort_d = 1'b1;
                end else if (bus.addr == acr_pkg::ADDR_THR) begin
                    if (!bus.bitop) begin
                        thr_d = bus.wdata[7:0];
                    end
                    abort_d = 1'b1;
                end
            end else begin
                if (bus.addr == acr_pkg::ADDR_RESULT_LO && bus.word) begin
                    rdata_d = result_word;
                end else if (bus.addr == acr_pkg::ADDR_RESULT_LO) begin
                    rdata_d = {8'h00, result_word[7:0]};
                end else if (bus.addr == acr_pkg::ADDR_RESULT_HI) begin
                    rdata_d = {8'h00, result_word[15:8]};
                end else if (bus.addr == acr_pkg::ADDR_CHAN) begin
                    rdata_d = {13'h0000, chan_q};
                end else if (bus.addr == acr_pkg::ADDR_MODE) begin
                    rdata_d = {8'h00, mode_byte};
                end else if (bus.addr == acr_pkg::ADDR_THR) begin
                    rdata_d = {8'h00, thr_q};
                end
            end
        end
    end

    // Register the bus side and control registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= acr_pkg::DEV_IDLE;
            wcnt_q <= 2'h0;
            ready_q <= 1'b0;
            rdata_q <= 16'h0000;
            chan_q <= acr_pkg::CHAN_RST;
            mode_q <= acr_pkg::MODE_RST;
            thr_q <= acr_pkg::THR_RST;
            abort_q <= 1'b0;
        end else begin
            state_q <= state_d;
            wcnt_q <= wcnt_d;
            ready_q <= ready_d;
            rdata_q <= rdata_d;
            chan_q <= chan_d;
            mode_q <= mode_d;
            thr_q <= thr_d;
            abort_q <= abort_d;
        end
    end

    // Result capture has no reset: its content is unknown until the
    // first conversion, which saves a reset tree on ten data flops
    always_ff @(posedge clock) begin
        if (conv_done) begin
            result_q <= sar_value;
        end
    end

    // Interrupt decision one cycle after capture, on the stored value
    always_comb begin
        eval_d = conv_done;
        irq_d = 1'b0;
        if (eval_q) begin
            if (!mode_q[1]) begin
                irq_d = 1'b1;
            end else if (mode_q[0]) begin
                irq_d = (result_hi < thr_q);
            end else begin
                irq_d = (result_hi >= thr_q);
            end
        end
    end

    // Register the interrupt path
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            eval_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            eval_q <= eval_d;
            irq_q <= irq_d;
        end
    end

    // Outputs straight from flops
    assign bus.ready = ready_q;
    assign bus.rdata = rdata_q;
    assign bus.irq = irq_q;
    assign conv_abort = abort_q;
    assign channel_sel = chan_q;
endmodule : acr_device
`default_nettype wire

// >>> rtl/acr_host.sv
// Controller end: takes orders over AXI4-Lite and runs single accesses
// on the memory bus of the converter registers.
// Assumes one clock shared with the device and a level sub_clk_only
// that is high while the CPU runs with the main oscillator stopped.
`timescale 1ns/10ps
`default_nettype none
module acr_host (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // AXI4-Lite slave
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [7:0] s_awaddr,
    input wire logic s_wvalid,
    output logic s_wready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    output logic s_bvalid,
    input wire logic s_bready,
    output logic [1:0] s_bresp,
    input wire logic s_arvalid,
    output logic s_arready,
    input wire logic [7:0] s_araddr,
    output logic s_rvalid,
    input wire logic s_rready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    // Clock status
    input wire logic sub_clk_only,
    // Memory bus to the device
    acr_if.host bus
);
    function automatic logic [15:0] lanes(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        logic [15:0] r;
        r = old;
        for (int i = 0; i < 2; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction : lanes

    acr_pkg::acr_host_st_t st_q, st_d;
    logic aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [15:0] addr_q, addr_d, wd_q, wd_d, rd_q, rd_d, baddr_q, baddr_d;
    logic [15:0] bwd_q, bwd_d;
    logic [7:0] cmd_q, cmd_d, irqcnt_q, irqcnt_d;
    logic refused_q, refused_d, unread_q, unread_d;
    logic start, slow, is_res;

    // AXI handshakes, controller registers and the access sequencer
    always_comb begin
        st_d = st_q;
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q && !s_bready;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q && !s_rready;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        addr_d = addr_q;
        wd_d = wd_q;
        rd_d = rd_q;
        baddr_d = baddr_q;
        bwd_d = bwd_q;
        cmd_d = cmd_q;
        irqcnt_d = irqcnt_q;
        refused_d = refused_q;
        unread_d = unread_q;
        start = 1'b0;
        slow = 1'b0;
        is_res = (addr_q == acr_pkg::ADDR_RESULT_LO ||
                  addr_q == acr_pkg::ADDR_RESULT_HI);
        if (s_awvalid && awready_q) begin
            aw_got_d = 1'b1;
            awaddr_d = s_awaddr;
        end
        if (s_wvalid && wready_q) begin
            w_got_d = 1'b1;
            wdata_d = s_wdata;
            wstrb_d = s_wstrb;
        end
        // Write once both halves are held and the last answer is gone
        if (aw_got_q && w_got_q && !bvalid_q) begin
            aw_got_d = 1'b0;
            w_got_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = acr_pkg::RESP_OKAY;
            if (awaddr_q == acr_pkg::OFS_ADDR) begin
                addr_d = lanes(addr_q, wdata_q, wstrb_q);
            end else if (awaddr_q == acr_pkg::OFS_WDATA) begin
                wd_d = lanes(wd_q, wdata_q, wstrb_q);
            end else if (awaddr_q == acr_pkg::OFS_CMD) begin
                cmd_d = wdata_q[7:0];
                start = wstrb_q[0];
            end else if (awaddr_q == acr_pkg::OFS_STATUS) begin
                if (wdata_q[acr_pkg::ST_REFUSED] && wstrb_q[0]) begin
                    refused_d = 1'b0;
                end
            end else begin
                bresp_d = acr_pkg::RESP_SLVERR;
            end
        end
        // Access sequencer
        case (st_q)
            acr_pkg::HOST_IDLE: begin
                if (start) begin
                    slow = sub_clk_only && (is_res ||
                           (wdata_q[acr_pkg::CMD_WRITE] &&
                            (addr_q == acr_pkg::ADDR_CHAN ||
                             addr_q == acr_pkg::ADDR_MODE ||
                             addr_q == acr_pkg::ADDR_THR ||
                             addr_q == acr_pkg::ADDR_CONV_MODE)));
                    if (slow) begin
                        refused_d = 1'b1;
                    end else if (wdata_q[acr_pkg::CMD_WRITE] && unread_q &&
                                 (addr_q == acr_pkg::ADDR_CHAN ||
                                  addr_q == acr_pkg::ADDR_CONV_MODE)) begin
                        refused_d = 1'b1;
                    end else begin
                        st_d = acr_pkg::HOST_REQ;
                        baddr_d = addr_q;
                        bwd_d = wd_q;
                        if (addr_q == acr_pkg::ADDR_CHAN) begin
                            bwd_d = {13'h0000, wd_q[2:0]};
                        end
                    end
                end
            end
            acr_pkg::HOST_REQ: begin
                if (start) begin
                    refused_d = 1'b1;
                    cmd_d = cmd_q;
                end
                if (bus.ready) begin
                    st_d = acr_pkg::HOST_IDLE;
                    rd_d = bus.rdata;
                    if (!cmd_q[acr_pkg::CMD_WRITE] &&
                        (baddr_q == acr_pkg::ADDR_RESULT_LO ||
                         baddr_q == acr_pkg::ADDR_RESULT_HI)) begin
                        unread_d = 1'b0;
                    end
                end
            end
            default: begin
                st_d = acr_pkg::HOST_IDLE;
            end
        endcase
        // A new result wins over a read that clears the flag
        if (bus.irq) begin
            unread_d = 1'b1;
            irqcnt_d = irqcnt_q + 8'h01;
        end
        awready_d = !aw_got_d;
        wready_d = !w_got_d;
        arready_d = !rvalid_d;
        if (s_arvalid && arready_q) begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rresp_d = acr_pkg::RESP_OKAY;
            rdata_d = 32'h00000000;
            if (s_araddr == acr_pkg::OFS_ADDR) begin
                rdata_d = {16'h0000, addr_q};
            end else if (s_araddr == acr_pkg::OFS_WDATA) begin
                rdata_d = {16'h0000, wd_q};
            end else if (s_araddr == acr_pkg::OFS_CMD) begin
                rdata_d = {24'h000000, cmd_q};
            end else if (s_araddr == acr_pkg::OFS_STATUS) begin
                rdata_d[acr_pkg::ST_BUSY] = (st_q == acr_pkg::HOST_REQ);
                rdata_d[acr_pkg::ST_REFUSED] = refused_q;
                rdata_d[acr_pkg::ST_UNREAD] = unread_q;
                rdata_d[acr_pkg::ST_IRQ_LO +: 8] = irqcnt_q;
            end else if (s_araddr == acr_pkg::OFS_RDATA) begin
                rdata_d = {16'h0000, rd_q};
            end else begin
                rresp_d = acr_pkg::RESP_SLVERR;
            end
        end
    end

    // Register everything
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= acr_pkg::HOST_IDLE;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= 2'h0;
            rdata_q <= 32'h00000000;
            addr_q <= 16'h0000;
            wd_q <= 16'h0000;
            rd_q <= 16'h0000;
            baddr_q <= 16'h0000;
            bwd_q <= 16'h0000;
            cmd_q <= 8'h00;
            irqcnt_q <= 8'h00;
            refused_q <= 1'b0;
            unread_q <= 1'b0;
        end else begin
            st_q <= st_d;
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            addr_q <= addr_d;
            wd_q <= wd_d;
            rd_q <= rd_d;
            baddr_q <= baddr_d;
            bwd_q <= bwd_d;
            cmd_q <= cmd_d;
            irqcnt_q <= irqcnt_d;
            refused_q <= refused_d;
            unread_q <= unread_d;
        end
    end

    // Outputs straight from flops; command fields are stable while busy, except on a command write with wstrb_q[0] clear
    assign s_awready = awready_q;
    assign s_wready = wready_q;
    assign s_bvalid = bvalid_q;
    assign s_bresp = bresp_q;
    assign s_arready = arready_q;
    assign s_rvalid = rvalid_q;
    assign s_rdata = rdata_q;
    assign s_rresp = rresp_q;
    assign bus.req = (st_q == acr_pkg::HOST_REQ);
    assign bus.we = cmd_q[acr_pkg::CMD_WRITE];
    assign bus.word = cmd_q[acr_pkg::CMD_WORD];
    assign bus.bitop = cmd_q[acr_pkg::CMD_BITOP];
    assign bus.bit_idx = cmd_q[acr_pkg::CMD_IDX_LO +: 3];
    assign bus.bit_val = cmd_q[acr_pkg::CMD_BITVAL];
    assign bus.addr = baddr_q;
    assign bus.wdata = bwd_q;
endmodule : acr_host
`default_nettype wire

// >>> verification/acr_bus_monitor.sv
// Bus checks between the controller and the converter registers.
// Assumes the bench wires the bus signals in by name.
`timescale 1ns/10ps
`default_nettype none
module acr_bus_monitor (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Memory bus
    input wire logic req,
    input wire logic we,
    input wire logic [15:0] addr,
    input wire logic [15:0] rdata,
    input wire logic ready,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic slow;
    // Accesses that cost one extra wait cycle
    assign slow = we ? (addr == acr_pkg::ADDR_CHAN
        || addr == acr_pkg::ADDR_MODE || addr == acr_pkg::ADDR_THR)
        : (addr[15:1] == 15'h7f84);
    AST_WAIT: assert property (
        $rose(req) && slow |=> !ready ##1 ready)
        else $error("slow access not answered after one wait");
    AST_FAST: assert property ($rose(req) && !slow |=> ready)
        else $error("plain access answered late");
    AST_PULSE: assert property (ready |=> !ready)
        else $error("ready longer than one cycle");
    AST_HELD: assert property (ready |-> req)
        else $error("answer without request");
    AST_RES: assert property (
        ready && !we && addr == acr_pkg::ADDR_RESULT_LO
        |-> rdata[5:0] == 6'h00)
        else $error("result low bits not zero");
    AST_MODE: assert property (
        ready && !we && addr == acr_pkg::ADDR_MODE
        |-> rdata[5:0] == 6'h00)
        else $error("mode low bits not zero");
    AST_CHAN: assert property (
        ready && !we && addr == acr_pkg::ADDR_CHAN
        |-> rdata[7:3] == 5'h00)
        else $error("select high bits not zero");
    AST_IRQ: assert property (irq |=> !irq)
        else $error("interrupt longer than one cycle");
endmodule : acr_bus_monitor
`default_nettype wire

// >>> verification/testbench.sv
// Bench: AXI software side and converter core joined by the bus.
// Assumes the controller and the register block share one clock.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clock, awr, wr, bv, arr, rv, conv_abort;
    logic rst_b = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic conv_done = 0, sub = 0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdat, st, rd;
    logic [1:0] bresp, rresp;
    logic [9:0] approximation_register = 10'h000;
    logic [2:0] chan;
    int n_mismatch = 0, n_compared = 0, n_abort = 0, ecnt = 0;
    acr_if bus ();
    acr_host acr_host_inst (.clock(clock), .rst_b(rst_b), .s_awvalid(awv),
        .s_awready(awr), .s_awaddr(awa), .s_wvalid(wv), .s_wready(wr),
        .s_wdata(wd), .s_wstrb(4'hf), .s_bvalid(bv), .s_bready(bry),
        .s_bresp(bresp), .s_arvalid(arv), .s_arready(arr), .s_araddr(ara),
        .s_rvalid(rv), .s_rready(rry), .s_rdata(rdat), .s_rresp(rresp),
        .sub_clk_only(sub), .bus(bus));
    acr_device acr_device_inst (.clock(clock), .rst_b(rst_b), .bus(bus),
        .conv_done(conv_done), .sar_value(approximation_register), .conv_abort(conv_abort),
        .channel_sel(chan));
    acr_bus_monitor acr_bus_monitor_inst (.clock(clock), .rst_b(rst_b),
        .req(bus.req), .we(bus.we), .addr(bus.addr), .rdata(bus.rdata),
        .ready(bus.ready), .irq(bus.irq));
    // Clock, 100 ns period
    initial begin
        clock = 0;
        forever #50 clock = ~clock;
    end
    // Count restart pulses
    always @(posedge clock) if (conv_abort === 1'b1) n_abort++;
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic complete_run;
        if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run
    // A spent wait bound ends the run
    task automatic hang(input int i);
        if (i >= 60) begin
            n_mismatch++;
            $display("Error %0t: no answer", $time);
            complete_run();
        end
    endtask : hang
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        awv <= 1;
        wv <= 1;
        awa <= a;
        wd <= d;
        bry <= 1;
        for (i = 0; i < 60; i++) begin
            @(posedge clock);
            if (awr) awv <= 0;
            if (wr) wv <= 0;
            if (bv === 1'b1) break;
        end
        bry <= 0;
        hang(i);
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d);
        int i;
        @(posedge clock);
        arv <= 1;
        ara <= a;
        rry <= 1;
        for (i = 0; i < 60; i++) begin
            @(posedge clock);
            if (arr) arv <= 0;
            if (rv === 1'b1) break;
        end
        d = rdat;
        rry <= 0;
        hang(i);
    endtask : axr
    // One bus access through the controller registers
    task automatic dop(input logic [15:0] a, input logic [7:0] c,
        input logic [15:0] w);
        int i;
        axw(acr_pkg::OFS_ADDR, {16'h0, a});
        axw(acr_pkg::OFS_WDATA, {16'h0, w});
        axw(acr_pkg::OFS_CMD, {24'h0, c});
        for (i = 0; i < 60; i++) begin
            axr(acr_pkg::OFS_STATUS, st);
            if (st[acr_pkg::ST_BUSY] === 1'b0) break;
        end
        hang(i);
        axr(acr_pkg::OFS_RDATA, rd);
    endtask : dop
    task automatic conv(input logic [9:0] v);
        @(posedge clock);
        conv_done <= 1;
        approximation_register <= v;
        @(posedge clock);
        conv_done <= 0;
        repeat (4) @(posedge clock);
    endtask : conv
    task automatic t_reset;
        for (int a = 16'hff29; a <= 16'hff2b; a++) begin
            dop(a[15:0], 8'h00, 16'h0);
            chk({8'h0, rd[7:0]}, 16'h0);
        end
    endtask : t_reset
    task automatic t_chan;
        for (int i = 0; i < 8; i++) begin
            dop(acr_pkg::ADDR_CHAN, 8'h01, i[15:0] | 16'hf8);
            chk({13'h0, chan}, i[15:0]);
        end
        chk(n_abort[15:0], 16'h8);
        dop(acr_pkg::ADDR_CHAN, 8'h15, 16'h0);
        chk({13'h0, chan}, 16'h5);
    endtask : t_chan
    task automatic t_cmp;
        logic [7:0] md [3] = '{8'h00, 8'h80, 8'hc0};
        logic [9:0] v;
        dop(acr_pkg::ADDR_THR, 8'h01, 16'h80);
        dop(acr_pkg::ADDR_THR, 8'h85, 16'h0);
        dop(acr_pkg::ADDR_THR, 8'h00, 16'h0);
        chk({8'h0, rd[7:0]}, 16'h80);
        foreach (md[k]) begin
            dop(acr_pkg::ADDR_MODE, 8'h01, {8'h0, md[k]});
            for (int j = 0; j < 2; j++) begin
                v = j ? 10'h1fc : 10'h200;
                conv(v);
                if (!md[k][7] || (md[k][6] ? v[9:2] < 8'h80 : v[9:2] >= 8'h80))
                    ecnt++;
                dop(acr_pkg::ADDR_RESULT_LO, 8'h02, 16'h0);
                chk(rd[15:0], {v, 6'h00});
                chk({8'h0, st[15:8]}, ecnt[15:0]);
                dop(acr_pkg::ADDR_RESULT_HI, 8'h00, 16'h0);
                chk({8'h0, rd[7:0]}, {8'h0, v[9:2]});
                dop(acr_pkg::ADDR_RESULT_LO, 8'h00, 16'h0);
                chk(rd[15:0], {8'h0, v[1:0], 6'h00});
            end
        end
    endtask : t_cmp
    task automatic t_sub;
        sub <= 1;
        dop(acr_pkg::ADDR_THR, 8'h01, 16'h33);
        chk({15'h0, st[acr_pkg::ST_REFUSED]}, 16'h1);
        sub <= 0;
        dop(acr_pkg::ADDR_THR, 8'h00, 16'h0);
        chk({8'h0, rd[7:0]}, 16'h80);
    endtask : t_sub
    // Reset, then the scenarios in turn
    initial begin
        repeat (20) @(posedge clock);
        rst_b <= 1;
        repeat (2) @(posedge clock);
        t_reset();
        t_chan();
        t_cmp();
        t_sub();
        complete_run();
    end
endmodule : testbench
`default_nettype wire
